// ==== hdl/usr_pkg.sv ====
// Constants for the clocked serial unit: register map, field positions,
// reset values and word lengths.
// Assumes a 32-bit APB slave with one aligned word per register.
package usr_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_RX_CTRL = 8'h00;
    localparam logic [7:0] OFS_RX_DATA = 8'h04;
    localparam logic [7:0] OFS_TX_CTRL = 8'h08;
    localparam logic [7:0] OFS_BAUD_CTRL = 8'h0C;
    localparam logic [7:0] OFS_DIV_HIGH = 8'h10;
    localparam logic [7:0] OFS_DIV_LOW = 8'h14;
    localparam logic [7:0] OFS_TX_DATA = 8'h18;
    localparam logic [7:0] OFS_FLAGS = 8'h1C;

    // ------------------------------------------------------------
    // Receive control and status fields
    // ------------------------------------------------------------
    localparam int RXC_PORT_EN = 7;
    localparam int RXC_NINE_SEL = 6;
    localparam int RXC_SINGLE_EN = 5;
    localparam int RXC_CONT_EN = 4;
    localparam int RXC_FRAME_ERR = 2;
    localparam int RXC_OVERRUN = 1;
    localparam int RXC_NINTH = 0;

    // ------------------------------------------------------------
    // Transmit control and status fields
    // ------------------------------------------------------------
    localparam int TXC_CLK_SRC = 7;
    localparam int TXC_NINE_SEL = 6;
    localparam int TXC_TX_EN = 5;
    localparam int TXC_SYNC = 4;
    localparam int TXC_SHIFT_EMPTY = 1;
    localparam int TXC_NINTH = 0;

    // ------------------------------------------------------------
    // Baud control fields and flag register fields
    // ------------------------------------------------------------
    localparam int BDC_IDLE_POL = 4;
    localparam int BDC_WIDE_DIV = 3;
    localparam int FLG_RX_DONE = 1;
    localparam int FLG_TX_EMPTY = 0;

    // ------------------------------------------------------------
    // Reset values and word lengths
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] WORD_BITS_8 = 4'h8;
    localparam logic [3:0] WORD_BITS_9 = 4'h9;

endpackage

// ==== hdl/usr_sync_core.sv ====
// Clocked half-duplex serial unit: master reception with single or
// continuous words, and transmission with a one-word buffer that keeps
// working on an external clock while the core is in a low-power mode.
// Assumes an APB master on clk and an external partner on the pins.
//
// Overview of operation
// - Either receive enable starts reception.
// - Data pin sampled on clock falling edge.
// - Single enable receives one word, then stops.
// - Continuous enable receives until software clears it or an overrun occurs.
// - Both enables set behaves as continuous.
// - Word received sets flag; enable gates request.
// - Ninth bit and errors shown in control.
// - Data read returns low eight bits.
// - Clearing continuous enable clears the error.
// - Sync, port enable, internal clock mean master.
// - Clearing clock source selects slave operation.
// - Slave takes its clock from the pin.
// - Slave keeps shifting during low-power modes.
// - Second word waits buffered, empty flag clear.
// - After first word, second loads, flag sets.
// - Buffer-empty request wakes the chip when enabled.
// - Buffer write with transmitter enabled starts sending.
// - Slave transmit equals master except clock, sleep.
// - Ninth receive bit only when nine-bit selected.
// - Master drives clock; polarity sets idle level.
// - Buffer-empty flag sets on load, clears on write.
// - Half duplex: receive and transmit exclude each other.
`timescale 1ns/1ps
module usr_sync_core
    import usr_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shiftClockIn,
    output logic shiftClockOut,
    output logic shiftClockOe,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    input wire logic lowPowerMode,
    input wire logic receiveInterruptEnable,
    input wire logic transmitInterruptEnable,
    output logic receiveCompleteFlag,
    output logic transmitBufferEmptyFlag,
    output logic receiveIrq,
    output logic transmitIrq,
    output logic wakeReq
);
    import usr_pkg::*;

    // Register group state.
    logic portEn_ff, nxt_portEn, nineRx_ff, nxt_nineRx, singleEn_ff, nxt_singleEn;
    logic contEn_ff, nxt_contEn, overrun_ff, nxt_overrun, rxNinth_ff, nxt_rxNinth;
    logic clkSrc_ff, nxt_clkSrc, nineTx_ff, nxt_nineTx, transmitter_enable_ff, nxt_transmitter_enable;
    logic syncMode_ff, nxt_syncMode, txNinth_ff, nxt_txNinth;
    logic idlePol_ff, nxt_idlePol, wideDiv_ff, nxt_wideDiv;
    logic [7:0] divHi_ff, nxt_divHi, divLo_ff, nxt_divLo;
    logic [7:0] txBuf_ff, nxt_txBuf, rxBuf_ff, nxt_rxBuf;
    logic txFull_ff, nxt_txFull, rcFlag_ff, nxt_rcFlag;
    logic [31:0] prdata_ff, nxt_prdata;
    // Link group state.
    logic [2:0] ckSync_ff, nxt_ckSync;
    logic [1:0] dtSync_ff, nxt_dtSync;
    logic [15:0] brgCnt_ff, nxt_brgCnt;
    logic ckLvl_ff, nxt_ckLvl, txBusy_ff, nxt_txBusy, txPend_ff, nxt_txPend;
    logic [8:0] rxSh_ff, nxt_rxSh, txSh_ff, nxt_txSh, rxWord;
    logic [3:0] rxCnt_ff, nxt_rxCnt, txCnt_ff, nxt_txCnt;
    // Shared decode.
    logic wrEn, rdData, master, anyRxEn, rxRun, ckRun, baudTick;
    logic riseEdge, fallEdge, rxDone, rxOvr, txLoad, txDone, txAllowed;
    logic [15:0] divVal;
    logic [3:0] rxLen, txLen;

    // Builds the read value of one register.
    function automatic logic [7:0] regRead(input logic [7:0] addr);
        case (addr)
            OFS_RX_CTRL: regRead = {portEn_ff, nineRx_ff, singleEn_ff, contEn_ff, 1'b0,
                                    1'b0, overrun_ff, rxNinth_ff};
            OFS_RX_DATA: regRead = rxBuf_ff;
            OFS_TX_CTRL: regRead = {clkSrc_ff, nineTx_ff, transmitter_enable_ff, syncMode_ff, 2'b00,
                                    !txBusy_ff, txNinth_ff};
            OFS_BAUD_CTRL: regRead = {3'b000, idlePol_ff, wideDiv_ff, 3'b000};
            OFS_DIV_HIGH: regRead = divHi_ff;
            OFS_DIV_LOW: regRead = divLo_ff;
            OFS_TX_DATA: regRead = txBuf_ff;
            OFS_FLAGS: regRead = {6'h00, rcFlag_ff, !txFull_ff};
            default: regRead = 8'h00;
        endcase
    endfunction

    // Tells whether an address hits a register.
    function automatic logic isMapped(input logic [7:0] addr);
        isMapped = (addr[1:0] == 2'b00) && (addr <= OFS_FLAGS);
    endfunction

    // ------------------------------------------------------------
    // Mode decode and edge finding
    // ------------------------------------------------------------
    // A master drives the clock from the divider; a slave edge-detects the pin.
    assign wrEn = psel && penable && pwrite && isMapped(paddr);
    assign rdData = psel && penable && !pwrite && (paddr == OFS_RX_DATA);
    assign master = portEn_ff && syncMode_ff && clkSrc_ff;
    assign anyRxEn = portEn_ff && syncMode_ff && (contEn_ff || singleEn_ff);
    assign rxRun = anyRxEn && !txBusy_ff && !overrun_ff;
    assign ckRun = master && !lowPowerMode && (rxRun || txBusy_ff || ckLvl_ff != idlePol_ff);
    assign divVal = wideDiv_ff ? {divHi_ff, divLo_ff} : {8'h00, divLo_ff};
    assign baudTick = ckRun && (brgCnt_ff == divVal);
    assign riseEdge = clkSrc_ff ? (baudTick && !ckLvl_ff) : (ckSync_ff[1] && !ckSync_ff[2]);
    assign fallEdge = clkSrc_ff ? (baudTick && ckLvl_ff) : (!ckSync_ff[1] && ckSync_ff[2]);
    assign rxLen = nineRx_ff ? WORD_BITS_9 : WORD_BITS_8;
    assign txLen = nineTx_ff ? WORD_BITS_9 : WORD_BITS_8;
    assign rxDone = rxRun && fallEdge && (rxCnt_ff == rxLen - 4'h1);
    assign rxOvr = rxDone && rcFlag_ff && !rdData;
    assign txAllowed = portEn_ff && syncMode_ff && transmitter_enable_ff;
    assign txLoad = txFull_ff && !txBusy_ff && txAllowed && !(contEn_ff || singleEn_ff);
    assign txDone = txBusy_ff && fallEdge && (txCnt_ff == txLen - 4'h1);

    // Word as it stands once the bit on the current falling edge is in.
    always_comb begin
        rxWord = rxSh_ff;
        rxWord[rxCnt_ff] = dtSync_ff[1];
    end

    // ------------------------------------------------------------
    // Register group
    // ------------------------------------------------------------
    // Software writes, flag updates and the read data register.
    always_comb begin
        nxt_portEn = portEn_ff;
        nxt_nineRx = nineRx_ff;
        nxt_singleEn = singleEn_ff;
        nxt_contEn = contEn_ff;
        nxt_overrun = overrun_ff;
        nxt_rxNinth = rxNinth_ff;
        nxt_clkSrc = clkSrc_ff;
        nxt_nineTx = nineTx_ff;
        nxt_transmitter_enable = transmitter_enable_ff;
        nxt_syncMode = syncMode_ff;
        nxt_txNinth = txNinth_ff;
        nxt_idlePol = idlePol_ff;
        nxt_wideDiv = wideDiv_ff;
        nxt_divHi = divHi_ff;
        nxt_divLo = divLo_ff;
        nxt_txBuf = txBuf_ff;
        nxt_rxBuf = rxBuf_ff;
        nxt_txFull = txFull_ff;
        nxt_rcFlag = rcFlag_ff;
        nxt_prdata = prdata_ff;
        // Read data is captured in the setup phase.
        if (psel && !penable) begin
            nxt_prdata = {24'h000000, regRead(paddr)};
        end
        // A single word ends the single enable unless continuous is on.
        if (rxDone && !contEn_ff) begin
            nxt_singleEn = 1'b0;
        end
        // Reading the data buffer clears the receive flag.
        if (rdData) begin
            nxt_rcFlag = 1'b0;
        end
        // The shift register is fed; the buffer becomes empty.
        if (txLoad) begin
            nxt_txFull = 1'b0;
        end
        if (wrEn) begin
            case (paddr)
                OFS_RX_CTRL: begin
                    nxt_portEn = pwdata[RXC_PORT_EN];
                    nxt_nineRx = pwdata[RXC_NINE_SEL];
                    nxt_singleEn = pwdata[RXC_SINGLE_EN];
                    nxt_contEn = pwdata[RXC_CONT_EN];
                    if (!pwdata[RXC_CONT_EN]) begin
                        nxt_overrun = 1'b0;
                    end
                end
                OFS_TX_CTRL: begin
                    nxt_clkSrc = pwdata[TXC_CLK_SRC];
                    nxt_nineTx = pwdata[TXC_NINE_SEL];
                    nxt_transmitter_enable = pwdata[TXC_TX_EN];
                    nxt_syncMode = pwdata[TXC_SYNC];
                    nxt_txNinth = pwdata[TXC_NINTH];
                end
                OFS_BAUD_CTRL: begin
                    nxt_idlePol = pwdata[BDC_IDLE_POL];
                    nxt_wideDiv = pwdata[BDC_WIDE_DIV];
                end
                OFS_DIV_HIGH: nxt_divHi = pwdata[7:0];
                OFS_DIV_LOW: nxt_divLo = pwdata[7:0];
                OFS_TX_DATA: begin
                    nxt_txBuf = pwdata[7:0];
                    nxt_txFull = 1'b1;
                end
                default: nxt_txFull = nxt_txFull;
            endcase
        end
        // A finished word lands in the buffer with its flag, unless unread data would be lost.
        if (rxOvr) begin
            nxt_overrun = 1'b1;
        end else if (rxDone) begin
            nxt_rxBuf = rxWord[7:0];
            nxt_rxNinth = nineRx_ff ? rxWord[8] : 1'b0;
            nxt_rcFlag = 1'b1;
        end
    end

    // Registers of the register group.
    always_ff @(posedge clk) begin
        if (srst) begin
            portEn_ff <= 1'b0;
            nineRx_ff <= 1'b0;
            singleEn_ff <= 1'b0;
            contEn_ff <= 1'b0;
            overrun_ff <= 1'b0;
            rxNinth_ff <= 1'b0;
            clkSrc_ff <= 1'b0;
            nineTx_ff <= 1'b0;
            transmitter_enable_ff <= 1'b0;
            syncMode_ff <= 1'b0;
            txNinth_ff <= 1'b0;
            idlePol_ff <= 1'b0;
            wideDiv_ff <= 1'b0;
            divHi_ff <= RST_BYTE;
            divLo_ff <= RST_BYTE;
            txBuf_ff <= RST_BYTE;
            rxBuf_ff <= RST_BYTE;
            txFull_ff <= 1'b0;
            rcFlag_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            portEn_ff <= nxt_portEn;
            nineRx_ff <= nxt_nineRx;
            singleEn_ff <= nxt_singleEn;
            contEn_ff <= nxt_contEn;
            overrun_ff <= nxt_overrun;
            rxNinth_ff <= nxt_rxNinth;
            clkSrc_ff <= nxt_clkSrc;
            nineTx_ff <= nxt_nineTx;
            transmitter_enable_ff <= nxt_transmitter_enable;
            syncMode_ff <= nxt_syncMode;
            txNinth_ff <= nxt_txNinth;
            idlePol_ff <= nxt_idlePol;
            wideDiv_ff <= nxt_wideDiv;
            divHi_ff <= nxt_divHi;
            divLo_ff <= nxt_divLo;
            txBuf_ff <= nxt_txBuf;
            rxBuf_ff <= nxt_rxBuf;
            txFull_ff <= nxt_txFull;
            rcFlag_ff <= nxt_rcFlag;
            prdata_ff <= nxt_prdata;
        end
    end

    // ------------------------------------------------------------
    // Link group
    // ------------------------------------------------------------
    // Pin synchronisers, clock divider and the two shift registers.
    always_comb begin
        nxt_ckSync = {ckSync_ff[1:0], shiftClockIn};
        nxt_dtSync = {dtSync_ff[0], serialDataIn};
        nxt_brgCnt = (!ckRun || baudTick) ? 16'h0000 : brgCnt_ff + 16'h0001;
        nxt_ckLvl = ckLvl_ff;
        nxt_rxSh = rxSh_ff;
        nxt_rxCnt = rxCnt_ff;
        nxt_txSh = txSh_ff;
        nxt_txCnt = txCnt_ff;
        nxt_txBusy = txBusy_ff;
        nxt_txPend = txPend_ff;
        // The master clock toggles per tick and rests at the chosen idle level.
        if (!master) begin
            nxt_ckLvl = idlePol_ff;
        end else if (baudTick) begin
            nxt_ckLvl = !ckLvl_ff;
        end
        // Bits are counted on falling edges only while reception runs.
        if (!rxRun) begin
            nxt_rxCnt = 4'h0;
        end else if (fallEdge) begin
            nxt_rxSh = rxWord;
            nxt_rxCnt = rxDone ? 4'h0 : rxCnt_ff + 4'h1;
        end
        // The partner samples on falling edges; the next bit goes out on the rising edge.
        // In slave mode the pin clock keeps this running whatever the core power state.
        if (!txAllowed) begin
            nxt_txBusy = 1'b0;
        end else if (txLoad) begin
            nxt_txSh = {txNinth_ff, txBuf_ff};
            nxt_txBusy = 1'b1;
            nxt_txCnt = 4'h0;
            nxt_txPend = 1'b0;
        end else if (txBusy_ff) begin
            if (fallEdge) begin
                nxt_txBusy = !txDone;
                nxt_txCnt = txCnt_ff + 4'h1;
                nxt_txPend = 1'b1;
            end else if (riseEdge && txPend_ff) begin
                nxt_txSh = {1'b0, txSh_ff[8:1]};
                nxt_txPend = 1'b0;
            end
        end
    end

    // Registers of the link group.
    always_ff @(posedge clk) begin
        if (srst) begin
            ckSync_ff <= 3'h0;
            dtSync_ff <= 2'h0;
            brgCnt_ff <= 16'h0000;
            ckLvl_ff <= 1'b0;
            rxSh_ff <= 9'h000;
            rxCnt_ff <= 4'h0;
            txSh_ff <= 9'h000;
            txCnt_ff <= 4'h0;
            txBusy_ff <= 1'b0;
            txPend_ff <= 1'b0;
        end else begin
            ckSync_ff <= nxt_ckSync;
            dtSync_ff <= nxt_dtSync;
            brgCnt_ff <= nxt_brgCnt;
            ckLvl_ff <= nxt_ckLvl;
            rxSh_ff <= nxt_rxSh;
            rxCnt_ff <= nxt_rxCnt;
            txSh_ff <= nxt_txSh;
            txCnt_ff <= nxt_txCnt;
            txBusy_ff <= nxt_txBusy;
            txPend_ff <= nxt_txPend;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero-wait APB answer; pins and requests.
    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !isMapped(paddr);
    assign shiftClockOut = ckLvl_ff;
    assign shiftClockOe = master;
    assign serialDataOut = txSh_ff[0];
    assign serialDataOe = txBusy_ff;
    assign receiveCompleteFlag = rcFlag_ff;
    assign transmitBufferEmptyFlag = !txFull_ff;
    assign receiveIrq = rcFlag_ff && receiveInterruptEnable;
    assign transmitIrq = !txFull_ff && transmitInterruptEnable;
    assign wakeReq = lowPowerMode && (receiveIrq || transmitIrq);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence loadThenEmpty;
        txLoad ##1 transmitBufferEmptyFlag;
    endsequence

    chk_rx_flag_set: assert property (@(posedge clk) disable iff (srst)
        rxDone && !rxOvr |=> rcFlag_ff) else $error("receive flag not set");
    chk_rx_buf_load: assert property (@(posedge clk) disable iff (srst)
        rxDone && !rxOvr |=> rxBuf_ff == $past(rxWord[7:0])) else $error("buffer not loaded");
    chk_single_stop: assert property (@(posedge clk) disable iff (srst)
        rxDone && !contEn_ff && !wrEn |=> !singleEn_ff ##1 (!singleEn_ff || $past(wrEn)))
        else $error("single word did not stop");
    chk_err_clear: assert property (@(posedge clk) disable iff (srst)
        $fell(contEn_ff) |-> !overrun_ff) else $error("error kept after clear");
    chk_load_flag: assert property (@(posedge clk) disable iff (srst)
        txLoad && !(wrEn && paddr == OFS_TX_DATA) |-> loadThenEmpty) else $error("empty flag missing");
    chk_write_flag: assert property (@(posedge clk) disable iff (srst)
        wrEn && paddr == OFS_TX_DATA |=> !transmitBufferEmptyFlag) else $error("flag not cleared");
    chk_half_duplex: assert property (@(posedge clk) disable iff (srst)
        txBusy_ff |-> rxCnt_ff == 4'h0) else $error("receive during transmit");
    chk_slave_clock: assert property (@(posedge clk) disable iff (srst)
        !clkSrc_ff |-> !shiftClockOe) else $error("slave drives clock");
    chk_clock_idle: assert property (@(posedge clk) disable iff (srst)
        master && !ckRun && !lowPowerMode |=> shiftClockOut == $past(idlePol_ff)) else $error("clock not idle");
    chk_wake_req: assert property (@(posedge clk) disable iff (srst)
        lowPowerMode && transmitBufferEmptyFlag && transmitInterruptEnable |-> wakeReq)
        else $error("no wake request");
    chk_sample_fall: assert property (@(posedge clk) disable iff (srst)
        rxRun && rxCnt_ff != $past(rxCnt_ff) && $past(rxRun) |-> $past(fallEdge))
        else $error("sample off falling edge");

endmodule

// ==== verification/usr_sync_core_bench.sv ====
// Self-checking bench for the clocked serial unit.
// Assumes a 100 MHz clock, APB register access and the partner model.
`timescale 1ns/1ps
module usr_sync_core_bench;
    import usr_pkg::*;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, lowPowerMode = 1'b0, rxIe = 1'b1, txIe = 1'b1;
    logic sClkIn, sClkOut, sClkOe, sDatIn, sDatOut, sDatOe, rxFlag, txFlag, rxIrq, txIrq, wake;
    int miscompares = 0, n_checks = 0, cyc = 0;
    usr_sync_core u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shiftClockIn(sClkIn), .shiftClockOut(sClkOut), .shiftClockOe(sClkOe),
        .serialDataIn(sDatIn), .serialDataOut(sDatOut), .serialDataOe(sDatOe),
        .lowPowerMode(lowPowerMode), .receiveInterruptEnable(rxIe),
        .transmitInterruptEnable(txIe), .receiveCompleteFlag(rxFlag),
        .transmitBufferEmptyFlag(txFlag), .receiveIrq(rxIrq), .transmitIrq(txIrq), .wakeReq(wake));
    usr_sync_partner u_partner (.shiftClockOut(sClkOut), .shiftClockOe(sClkOe), .serialDataOut(sDatOut),
        .serialDataOe(sDatOe), .shiftClockIn(sClkIn), .serialDataIn(sDatIn));
    // Clock generation and the hang limit.
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            close_out();
        end
    end
    // Compares one value and counts it.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer: setup, then access held until pready.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits a bounded time for the receive flag.
    task automatic wait_rx();
        for (int i = 0; i < 400 && rxFlag !== 1'b1; i++) @(posedge clk);
    endtask
    // Reset values, idle polarity and an unmapped address.
    task automatic t_reset();
        apb(1'b0, OFS_FLAGS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, OFS_RX_CTRL, 32'h80);
        apb(1'b1, OFS_TX_CTRL, 32'h90);
        apb(1'b1, OFS_BAUD_CTRL, 32'h10);
        repeat (3) @(posedge clk);
        chk({sClkOe, sClkOut}, 2'b11);
        apb(1'b1, OFS_BAUD_CTRL, 32'h00);
        repeat (3) @(posedge clk);
        chk({sClkOe, sClkOut}, 2'b10);
    endtask
    // Single master reception of one 8-bit word.
    task automatic t_single();
        apb(1'b1, OFS_DIV_LOW, 32'h3);
        apb(1'b1, OFS_RX_CTRL, 32'h80);
        u_partner.load(9'h0A5, 8);
        apb(1'b1, OFS_RX_CTRL, 32'hA0);
        wait_rx();
        chk({rxFlag, rxIrq}, 2'b11);
        repeat (40) @(posedge clk);
        chk(sClkOut, 1'b0);
        apb(1'b0, OFS_RX_CTRL, 32'h0);
        chk(rd, 32'h80);
        apb(1'b0, OFS_RX_DATA, 32'h0);
        chk(rd, 32'hA5);
        @(posedge clk);
        chk(rxFlag, 1'b0);
    endtask
    // Continuous 9-bit reception with both enables, then overrun and its clear.
    task automatic t_cont();
        u_partner.load(9'h13C, 9);
        apb(1'b1, OFS_RX_CTRL, 32'hF0);
        wait_rx();
        apb(1'b0, OFS_RX_CTRL, 32'h0);
        chk(rd & 32'h51, 32'h51);
        apb(1'b0, OFS_RX_DATA, 32'h0);
        chk(rd, 32'h3C);
        repeat (5) @(posedge clk);
        wait_rx();
        chk(rxFlag, 1'b1);
        repeat (200) @(posedge clk);
        apb(1'b0, OFS_RX_CTRL, 32'h0);
        chk(rd & 32'h2, 32'h2);
        apb(1'b1, OFS_RX_CTRL, 32'hC0);
        apb(1'b0, OFS_RX_CTRL, 32'h0);
        chk(rd & 32'h12, 32'h0);
        apb(1'b0, OFS_RX_DATA, 32'h0);
    endtask
    // Slave transmission of two buffered words across a low-power period.
    task automatic t_slave();
        apb(1'b1, OFS_RX_CTRL, 32'h80);
        apb(1'b1, OFS_TX_CTRL, 32'h30);
        apb(1'b1, OFS_TX_DATA, 32'h5A);
        apb(1'b1, OFS_TX_DATA, 32'hC3);
        repeat (4) @(posedge clk);
        chk({txFlag, sDatOe, sClkOe}, 3'b010);
        lowPowerMode <= 1'b1;
        u_partner.clock_bits(8);
        chk(u_partner.got, 9'h05A);
        repeat (6) @(posedge clk);
        chk({txFlag, txIrq, wake}, 3'b111);
        u_partner.clock_bits(8);
        chk(u_partner.got, 9'h0C3);
        lowPowerMode <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b1, OFS_TX_CTRL, 32'h71);
        apb(1'b1, OFS_TX_DATA, 32'h96);
        u_partner.clock_bits(9);
        chk(u_partner.got, 9'h196);
        repeat (6) @(posedge clk);
        apb(1'b1, OFS_RX_CTRL, 32'h90);
        apb(1'b1, OFS_TX_DATA, 32'h11);
        repeat (10) @(posedge clk);
        chk(sDatOe, 1'b0);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_single();
        t_cont();
        t_slave();
        close_out();
    end
endmodule

// ==== verification/usr_sync_partner.sv ====
// Behavioural far-side device on the shift clock and data pins.
// Assumes the pin levels are resolved here from the unit's enables.
`timescale 1ns/1ps
module usr_sync_partner (
    input wire logic shiftClockOut,
    input wire logic shiftClockOe,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    output logic shiftClockIn,
    output logic serialDataIn
);
    logic pClk = 1'b0;
    logic pData = 1'b0;
    logic [8:0] word = 9'h000;
    logic [8:0] got = 9'h000;
    int nBits = 8;
    int idx = 0;
    // The pins carry whichever side has its driver enabled.
    assign shiftClockIn = shiftClockOe ? shiftClockOut : pClk;
    assign serialDataIn = serialDataOe ? serialDataOut : pData;
    // A new bit goes out on each rising master clock, LSB first, word repeating.
    always @(posedge shiftClockIn) begin
        if (shiftClockOe) begin
            pData <= word[idx];
            idx = (idx + 1) % nBits;
        end
    end
    // Loads the word to send; the line flips so a stale bit is never reused.
    task automatic load(input logic [8:0] w, input int n);
        word = w;
        nBits = n;
        idx = 0;
        pData = ~pData;
    endtask
    // Drives n clock pulses at 160 ns and samples data before each falling edge.
    task automatic clock_bits(input int n);
        got = 9'h000;
        #3;
        for (int i = 0; i < n; i++) begin
            #80 pClk = 1'b1;
            #80 got[i] = serialDataIn;
            pClk = 1'b0;
        end
    endtask
endmodule
